// ==== hdl/ilseq_top.sv ====
// Purpose: Exposure, transfer, readout and binning sequencer for an interline array
// Assumes: Config is stable while frame_busy_o is low; digitiser answers in one cycle
// Notes:   Pixels outside the readout window are clocked out and dropped
// Function
// - Short exposure forces non-overlapped operation
// - Non-overlapped: no exposure during readout
// - Transfer to storage before any row shift
// - Row into register, pixels to node
// - Imaging cells off during non-overlapped readout
// - Array empty before next exposure
// - Free run restarts accumulation at once
// - Ext sync waits for sync pulse for the first frame and non-overlapped frames, unless early_open is set
// - Overlapped: exposure restarts after transfer
// - Overlapped: exposure runs to programmed end
// - Budget: line shift per row, shift+convert per pixel
// - Window readout, outside pixels discarded
// - Vertical binning sums n rows
// - Horizontal binning sums n pixels, one conversion
// - Independent bin factors, each at least one
// - Binned budget scales by n and n squared
// - Conversion paced at 1 MHz
`timescale 1ns/1ps
`default_nettype none

module ilseq_top
    import ilseq_pkg::*;
(
    input  wire logic                        clock_i,
    input  wire logic                        rstn_i,
    input  wire ilseq_pkg::ilseq_cfg_type    cfg_i,
    input  wire logic                        start_i,
    input  wire logic                        ext_sync_i,
    input  wire logic [ilseq_pkg::PIX_W-1:0] adc_data_i,
    output logic                             image_on_o,
    output logic                             xfer_to_storage_o,
    output logic                             line_shift_o,
    output logic                             reg_shift_o,
    output logic                             node_reset_o,
    output logic                             adc_convert_o,
    output ilseq_pkg::ilseq_pix_type         pix_o,
    output logic                             overlapped_o,
    output logic                             frame_busy_o,
    output logic                             readout_busy_o
);
    import ilseq_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_WAIT_SYNC, S_EXPOSE, S_XFER, S_LINE, S_SHIFT, S_CONV
    } ilseq_state_type;

    ilseq_state_type    state_q, state_d;
    ilseq_cfg_type      cfg_q;
    logic               run_q, overlap_q, exp_done_q, rd_busy_q, img_on_q;
    logic [CNT_W-1:0]   exp_cnt_q, tmr_q;
    logic [COORD_W-1:0] row_q, col_q;
    logic [BIN_W-1:0]   vsum_q, hsum_q;
    logic               sync_m_q, sync_s_q, sync_d_q, sync_p_q;
    ilseq_pix_type      pix_q;

    // Cycle count of one binned readout, integer arithmetic only
    function automatic logic [CNT_W-1:0] readout_budget(input ilseq_cfg_type c);
        logic [CNT_W-1:0] rows;
        logic [CNT_W-1:0] shifts;
        logic [CNT_W-1:0] convs;
        rows   = CNT_W'(ARRAY_ROWS);
        shifts = CNT_W'(ARRAY_COLS) * rows / CNT_W'(c.bin_h);
        convs  = shifts / CNT_W'(c.bin_v);
        readout_budget = rows * CNT_W'(LINE_CYCLES) + shifts * CNT_W'(SHIFT_CYCLES)
                       + convs * CNT_W'(CONV_CYCLES);
    endfunction

    // Clamp a bin factor so a zero setting acts as one
    function automatic logic [BIN_W-1:0] min_one(input logic [BIN_W-1:0] v);
        min_one = (v == '0) ? BIN_W'(1) : v;
    endfunction

    ilseq_cfg_type    cfg_fix;
    wire [CNT_W-1:0]  rd_budget = readout_budget(cfg_fix);
    wire              short_exp = cfg_i.exp_cycles < rd_budget;
    wire              tmr_done  = (tmr_q == '0);
    wire              last_col  = (col_q == ARRAY_COLS - 12'h001);
    wire              last_row  = (row_q == ARRAY_ROWS - 12'h001);
    // Group counters start at zero, so a group closes on count bin minus one
    wire              grp_full  = (hsum_q == cfg_q.bin_h - BIN_W'(1)) || last_col;
    wire              vgrp_full = (vsum_q == cfg_q.bin_v - BIN_W'(1)) || last_row;
    wire              in_win    = (col_q >= cfg_q.win_x0)
                              && (col_q <  cfg_q.win_x0 + cfg_q.win_w)
                              && (row_q >= cfg_q.win_y0)
                              && (row_q <  cfg_q.win_y0 + cfg_q.win_h);
    wire              exp_end   = img_on_q && (exp_cnt_q == '0);
    // Trigger choice of the frame about to start; the latched copy is stale here
    wire              ready_exp = cfg_i.trig_mode == ILSEQ_FREE_RUN
                              || cfg_i.early_open || sync_p_q;

    always_comb
    begin
        cfg_fix       = cfg_i;
        cfg_fix.bin_h = min_one(cfg_i.bin_h);
        cfg_fix.bin_v = min_one(cfg_i.bin_v);
    end

    // Sync pin from outside: two flops, edge detect behind them so no logic
    // ever reads the possibly metastable first stage
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            sync_m_q <= 1'b0;
            sync_s_q <= 1'b0;
            sync_d_q <= 1'b0;
            sync_p_q <= 1'b0;
        end
        else
        begin
            sync_m_q <= ext_sync_i;
            sync_s_q <= sync_m_q;
            sync_d_q <= sync_s_q;
            sync_p_q <= sync_s_q & ~sync_d_q;
        end
    end

    // Readout engine state sequencing
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE:      if (start_i) state_d = S_WAIT_SYNC;
            S_WAIT_SYNC: if (ready_exp) state_d = S_EXPOSE;
            S_EXPOSE:    if (exp_end) state_d = S_XFER;
            S_XFER:      if (tmr_done) state_d = S_LINE;
            S_LINE:      if (tmr_done && vgrp_full) state_d = S_SHIFT;
            S_SHIFT:     if (tmr_done && grp_full) state_d = S_CONV;
            S_CONV:
                if (tmr_done)
                begin
                    if (!last_col)
                        state_d = S_SHIFT;
                    else if (!last_row)
                        state_d = S_LINE;
                    else if (!run_q)
                        state_d = S_IDLE;
                    else if (overlap_q)
                        state_d = exp_done_q ? S_XFER : S_EXPOSE;
                    else
                        state_d = S_WAIT_SYNC;
                end
        endcase
    end

    // Frame control: latch settings, time the exposure, hold imaging state
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            state_q    <= S_IDLE;
            cfg_q      <= '0;
            run_q      <= 1'b0;
            overlap_q  <= 1'b0;
            img_on_q   <= 1'b0;
            exp_cnt_q  <= '0;
            exp_done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == S_IDLE && start_i)
                run_q <= 1'b1;
            if (state_q == S_WAIT_SYNC && ready_exp)
            begin
                cfg_q     <= cfg_fix;
                overlap_q <= ~short_exp;
                img_on_q  <= 1'b1;
                exp_cnt_q <= cfg_i.exp_cycles;
            end
            else if (state_q == S_XFER && tmr_done)
            begin
                img_on_q   <= overlap_q;
                exp_cnt_q  <= cfg_q.exp_cycles;
                exp_done_q <= 1'b0;
            end
            else if (exp_end && state_q != S_EXPOSE)
            begin
                exp_done_q <= 1'b1;
            end
            else if (img_on_q && exp_cnt_q != '0)
                exp_cnt_q <= exp_cnt_q - CNT_W'(1);
            if (state_q == S_CONV && tmr_done && last_col && last_row && !overlap_q)
                img_on_q <= 1'b0;
        end
    end

    // Step timer and array position counters
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            tmr_q     <= '0;
            row_q     <= '0;
            col_q     <= '0;
            vsum_q    <= '0;
            hsum_q    <= '0;
            rd_busy_q <= 1'b0;
        end
        else
        begin
            if (state_d != state_q || tmr_done)
            begin
                unique case (state_d)
                    S_XFER:  tmr_q <= CNT_W'(XFER_CYCLES - 1);
                    S_LINE:  tmr_q <= CNT_W'(LINE_CYCLES - 1);
                    S_SHIFT: tmr_q <= CNT_W'(SHIFT_CYCLES - 1);
                    S_CONV:  tmr_q <= CNT_W'(CONV_CYCLES - 1);
                    default: tmr_q <= '0;
                endcase
            end
            else
                tmr_q <= tmr_q - CNT_W'(1);
            if (state_q == S_XFER && tmr_done)
            begin
                row_q     <= '0;
                col_q     <= '0;
                vsum_q    <= '0;
                hsum_q    <= '0;
                rd_busy_q <= 1'b1;
            end
            if (state_q == S_LINE && tmr_done)
            begin
                vsum_q <= vsum_q + BIN_W'(1);
                if (!vgrp_full)
                    row_q <= row_q + 12'h001;
            end
            if (state_q == S_SHIFT && tmr_done)
            begin
                hsum_q <= hsum_q + BIN_W'(1);
                if (!grp_full)
                    col_q <= col_q + 12'h001;
            end
            if (state_q == S_CONV && tmr_done)
            begin
                hsum_q <= '0;
                if (!last_col)
                    col_q <= col_q + 12'h001;
                else
                begin
                    col_q  <= '0;
                    vsum_q <= '0;
                    row_q  <= row_q + 12'h001;
                    if (last_row)
                        rd_busy_q <= 1'b0;
                end
            end
            if (state_q == S_LINE && state_d == S_SHIFT)
                hsum_q <= '0;
        end
    end

    // Digitised samples leave as registered words
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            pix_q <= '0;
        else
        begin
            pix_q.valid      <= state_q == S_CONV && tmr_done && in_win;
            pix_q.frame_last <= last_col && last_row;
            pix_q.data       <= adc_data_i;
        end
    end

    // Strobes towards the array and digitiser
    assign image_on_o        = img_on_q;
    assign xfer_to_storage_o = (state_q == S_XFER);
    assign line_shift_o      = (state_q == S_LINE) && tmr_done;
    assign reg_shift_o       = (state_q == S_SHIFT) && tmr_done;
    assign adc_convert_o     = (state_q == S_CONV) && tmr_done;
    assign node_reset_o      = (state_q == S_LINE) && (state_d == S_SHIFT);
    assign pix_o             = pix_q;
    assign overlapped_o      = overlap_q;
    assign frame_busy_o      = (state_q != S_IDLE) && (state_q != S_WAIT_SYNC);
    assign readout_busy_o    = rd_busy_q;

endmodule

`default_nettype wire

// ==== hdl/ilseq_pkg.sv ====
// Purpose: Shared constants and types for the interline readout sequencer
// Assumes: 200 MHz pixel-domain clock; array sizes fixed at elaboration
// Notes:   All timing figures are kept in their own units and converted here
package ilseq_pkg;

    localparam int CLK_MHZ        = 200;
    localparam int CONV_RATE_MHZ  = 1;          // Digitiser conversion rate
    localparam int CONV_CYCLES    = CLK_MHZ / CONV_RATE_MHZ;
    localparam int LINE_SHIFT_NS  = 1000;       // Time to move one row into the register
    localparam int LINE_CYCLES    = (LINE_SHIFT_NS * CLK_MHZ + 999) / 1000;
    localparam int REG_SHIFT_NS   = 100;        // Time to move one pixel out of the register
    localparam int SHIFT_CYCLES   = (REG_SHIFT_NS * CLK_MHZ + 999) / 1000;
    localparam int XFER_NS        = 1000;       // Image to storage transfer
    localparam int XFER_CYCLES    = (XFER_NS * CLK_MHZ + 999) / 1000;

    localparam int COORD_W = 12;
    localparam int BIN_W   = 4;
    localparam int CNT_W   = 32;
    localparam int PIX_W   = 16;

    localparam logic [COORD_W-1:0] ARRAY_COLS = 12'h514;
    localparam logic [COORD_W-1:0] ARRAY_ROWS = 12'h406;

    typedef enum logic { ILSEQ_FREE_RUN, ILSEQ_EXT_SYNC } ilseq_trig_type;

    typedef struct packed {
        ilseq_trig_type         trig_mode;
        logic                   early_open;   // shutter_early_open_option
        logic [CNT_W-1:0]       exp_cycles;
        logic [COORD_W-1:0]     win_x0;       // readout_window origin and size
        logic [COORD_W-1:0]     win_y0;
        logic [COORD_W-1:0]     win_w;
        logic [COORD_W-1:0]     win_h;
        logic [BIN_W-1:0]       bin_h;
        logic [BIN_W-1:0]       bin_v;
    } ilseq_cfg_type;

    typedef struct packed {
        logic                   valid;
        logic                   frame_last;
        logic [PIX_W-1:0]       data;
    } ilseq_pix_type;

endpackage

// ==== tb/ilseq_sva.sv ====
// Purpose: Port-level checks for the readout sequencer
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to ilseq_top from tb
`timescale 1ns/1ps
`default_nettype none
module ilseq_sva
    import ilseq_pkg::*;
(
    input wire logic                    clock_i,
    input wire logic                    rstn_i,
    input wire logic                    image_on_o,
    input wire logic                    xfer_to_storage_o,
    input wire logic                    line_shift_o,
    input wire logic                    reg_shift_o,
    input wire logic                    node_reset_o,
    input wire logic                    adc_convert_o,
    input wire ilseq_pkg::ilseq_pix_type pix_o,
    input wire logic [ilseq_pkg::PIX_W-1:0] adc_data_i,
    input wire logic                    overlapped_o,
    input wire logic                    frame_busy_o,
    input wire logic                    readout_busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic [15:0] xfer_q;
    logic [15:0] gap_q;
    // Run lengths; gap starts full so the first conversion after reset is legal
    always_ff @(posedge clock_i)
    begin
        xfer_q <= (rstn_i && xfer_to_storage_o) ? xfer_q + 16'h1 : 16'h0;
        gap_q  <= !rstn_i ? 16'(CONV_CYCLES) : adc_convert_o ? 16'h1 :
                  (gap_q < 16'(CONV_CYCLES)) ? gap_q + 16'h1 : gap_q;
    end
    a_xfer_len: assert property ($fell(xfer_to_storage_o) |-> xfer_q == 16'(XFER_CYCLES))
        else $error("transfer length wrong");
    a_conv_spacing: assert property (adc_convert_o |-> gap_q >= 16'(CONV_CYCLES))
        else $error("conversions too close");
    a_pix_cause: assert property (pix_o.valid |-> $past(adc_convert_o))
        else $error("pixel without conversion");
    a_pix_data: assert property (pix_o.valid |-> pix_o.data == $past(adc_data_i))
        else $error("pixel data not the sample");
    a_dark_readout: assert property (readout_busy_o && !overlapped_o |-> !image_on_o)
        else $error("imaging on during readout");
    a_xfer_first: assert property (xfer_to_storage_o |-> !(line_shift_o || reg_shift_o))
        else $error("shift during transfer");
    a_line_alone: assert property (line_shift_o |-> !reg_shift_o && !adc_convert_o)
        else $error("row and pixel shift together");
    // Node is cleared with the last row shift of the group, then the first pixel step takes 20 cycles
    a_node_then_shift: assert property (node_reset_o |-> ##20 reg_shift_o)
        else $error("no pixel shift after node reset");
    a_idle_quiet: assert property (!frame_busy_o |-> !(line_shift_o || adc_convert_o))
        else $error("activity while idle");
    cover property (adc_convert_o);
    cover property ($rose(xfer_to_storage_o));
    cover property (pix_o.valid);
endmodule
`default_nettype wire

// ==== tb/ilseq_adc_model.sv ====
// Purpose: Digitiser stand-in on the far side of the sequencer
// Assumes: Sample is read in the conversion cycle
// Notes:   Outside conversions the line carries noise, never a stale sample
`timescale 1ns/1ps
`default_nettype none
module ilseq_adc_model
    import ilseq_pkg::*;
(
    input  wire logic                        clock_i,
    input  wire logic                        rstn_i,
    input  wire logic                        convert_i,
    output logic [ilseq_pkg::PIX_W-1:0]      data_o
);
    logic [PIX_W-1:0] samp_q;
    logic [PIX_W-1:0] noise_q;
    // One fresh sample per conversion, so a missed capture shows up
    assign data_o = convert_i ? samp_q : noise_q;
    always_ff @(posedge clock_i)
    begin
        noise_q <= !rstn_i ? 16'h5A5A : noise_q + 16'h1D37;
        samp_q  <= !rstn_i ? 16'h3C00 : convert_i ? samp_q + 16'h1 : samp_q;
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the readout sequencer
// Assumes: Full frame exceeds run length, so first groups are checked
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ilseq_pkg::*;
    logic clock_i, rstn_i, start_i, ext_sync_i;
    logic img, xfer, line, rsh, conv, ovl, busy, rbusy;
    logic [PIX_W-1:0] adc;
    ilseq_cfg_type cfg;
    ilseq_pix_type pix;
    int seed = 20;
    int err_total = 0;
    int tests_run = 0;
    int n;
    ilseq_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .cfg_i(cfg), .start_i(start_i),
        .ext_sync_i(ext_sync_i), .adc_data_i(adc), .image_on_o(img), .xfer_to_storage_o(xfer),
        .line_shift_o(line), .reg_shift_o(rsh), .node_reset_o(), .adc_convert_o(conv),
        .pix_o(pix), .overlapped_o(ovl), .frame_busy_o(busy), .readout_busy_o(rbusy));
    ilseq_adc_model adc_m (.clock_i(clock_i), .rstn_i(rstn_i), .convert_i(conv), .data_o(adc));
    // Free-running clock
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp_v, input string what);
        tests_run++;
        if (got !== exp_v)
        begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp_v);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return img;
            1: return xfer;
            2: return rsh;
            3: return conv;
            default: return line;
        endcase
    endfunction
    // Count pulses of c until s is seen; bounded so a hang ends the run
    task automatic count_until(input int s, input int c, output int cnt);
        int i;
        cnt = 0;
        for (i = 0; i < 20000 && sig(s) !== 1'b1; i++)
        begin
            cnt += int'(sig(c) === 1'b1);
            tick(1);
        end
        if (i == 20000)
        begin
            chk(0, 1, "timeout");
            tally_and_finish();
        end
    endtask
    task automatic pulse_start();
        start_i = 1'b1;
        tick(1);
        start_i = 1'b0;
    endtask
    // First row group: bv row shifts, then bh pixel shifts, one conversion
    task automatic first_group(input int bv, input int bh, input logic inwin);
        count_until(2, 4, n);
        chk(n, bv, "rows per group");
        chk(img, 0, "imaging off");
        chk(rbusy, 1, "readout busy");
        count_until(3, 2, n);
        chk(n, bh, "pixels per conversion");
        tick(1);
        chk(pix.valid, inwin, "window");
        chk(pix.frame_last, 0, "not frame end");
        if (inwin)
            chk(pix.data, 16'h3C00, "sample");
    endtask
    initial
    begin
        rstn_i = 1'b0;
        start_i = 1'b0;
        ext_sync_i = 1'b0;
        cfg = '0;
        tick(16);
        chk({img, xfer, line, rsh, conv, busy}, 0, "reset");
        rstn_i = 1'b1;
        // Free run, short exposure, random bins over full array
        cfg.exp_cycles = 32'(100 + ($random(seed) & 255));
        cfg.bin_h = 4'(1 + ($random(seed) & 3));
        cfg.bin_v = 4'(1 + ($random(seed) & 3));
        cfg.win_w = ARRAY_COLS;
        cfg.win_h = ARRAY_ROWS;
        pulse_start();
        count_until(1, 0, n);
        // Imaging is on for the count plus the cycle that ends it before transfer starts
        chk(n, cfg.exp_cycles + 32'h1, "exposure");
        chk(ovl, 0, "short exposure mode");
        first_group(cfg.bin_v, cfg.bin_h, 1'b1);
        tick(300);
        chk(img, 0, "imaging off");
        // Mid-run reset, then ext sync with zero bins and shifted window
        rstn_i = 1'b0;
        tick(2);
        chk({img, xfer, line, rsh, conv, busy}, 0, "reset");
        rstn_i = 1'b1;
        cfg.trig_mode = ILSEQ_EXT_SYNC;
        cfg.bin_h = 4'h0;
        cfg.bin_v = 4'h0;
        cfg.win_x0 = 12'h001;
        cfg.win_w = ARRAY_COLS - 12'h001;
        pulse_start();
        tick(40);
        chk(img, 0, "waits for sync");
        ext_sync_i = 1'b1;
        tick(2);
        ext_sync_i = 1'b0;
        count_until(0, 0, n);
        count_until(1, 0, n);
        chk(n, cfg.exp_cycles + 32'h1, "exposure");
        first_group(1, 1, 1'b0);
        // Long exposure selects overlapped operation
        rstn_i = 1'b0;
        tick(2);
        rstn_i = 1'b1;
        cfg.trig_mode = ILSEQ_FREE_RUN;
        cfg.exp_cycles = 32'hFFFFFFFF;
        pulse_start();
        tick(5);
        chk(ovl, 1, "long exposure mode");
        chk(img, 1, "exposing");
        tally_and_finish();
    end
endmodule
bind ilseq_top ilseq_sva u_sva (.clock_i(clock_i), .rstn_i(rstn_i), .image_on_o(image_on_o),
    .xfer_to_storage_o(xfer_to_storage_o), .line_shift_o(line_shift_o),
    .reg_shift_o(reg_shift_o), .node_reset_o(node_reset_o),
    .adc_convert_o(adc_convert_o), .pix_o(pix_o),
    .adc_data_i(adc_data_i), .overlapped_o(overlapped_o), .frame_busy_o(frame_busy_o),
    .readout_busy_o(readout_busy_o));
`default_nettype wire
